/* File: src/spd_cfg.svh */
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
// Notes on behaviour
// - eight strap pins each give a four-bit code, thirty-two configuration bits in all.
// - pin 7 bit 2 presets the speed downshift enable, one meaning downshift allowed.
// - pin 7 bits 1:0 pick the speed and duplex advertisement set of four choices.
// - pin 6 bit 3 presets mac-side autoneg and bit 2 the link-down power save, one enables.
// - pin 6 bits 1 and 0 preset asymmetric and symmetric pause advertisement.
// - bit 3 of pins 5, 4, 3 form the three-bit media interface select, code 100 reserved.
// - pass-through fiber modes skip fiber autoneg while 1000base-x modes run it in the phy.
// - pin 5 bits 2, 1, 0 give signal detect polarity, reference clock speed, clock output.
// - pin 4 bit 2 picks fiber/copper indicator combine and bits 1:0 the blink rate.
// - pins 3 to 0 bit 2 pick combine or separate and bits 1:0 the indicator function.
// - pin 2 bit 3 selects address reversal, pins 1 and 0 bit 3 give address bits 4 and 3.
// - without reversal port n takes address n, with reversal port n takes address 7-n.
// - the two strapped bits are the top two bits of each port's five-bit address.

// ------------------------------------------------------------
// strap layout
// ------------------------------------------------------------
`define SPD_NUM_PINS      8
`define SPD_CODE_W        4
`define SPD_NUM_PORTS     8
`define SPD_ADDR_W        5
`define SPD_BIT_HI        3
`define SPD_BIT_MID       2
`define SPD_BIT_ONE       1
`define SPD_BIT_ZERO      0
`define SPD_PIN_SPEED     7
`define SPD_PIN_MAC       6
`define SPD_PIN_MEDIA2    5
`define SPD_PIN_MEDIA1    4
`define SPD_PIN_MEDIA0    3
`define SPD_PIN_REV       2
`define SPD_PIN_ADDR4     1
`define SPD_PIN_ADDR3     0
`define SPD_PORT_MAX      3'h7
`define SPD_NUM_IND       4

// ------------------------------------------------------------
// media codes and advertisement
// ------------------------------------------------------------
`define SPD_MEDIA_PASS    3'h1
`define SPD_MEDIA_1000X   3'h2
`define SPD_MEDIA_RSVD    3'h4
`define SPD_MEDIA_AS_PASS 3'h5
`define SPD_MEDIA_AS_1000 3'h6
`define SPD_MEDIA_COPPER  3'h0
`define SPD_MEDIA_100X    3'h3
`define SPD_MEDIA_AS_100  3'h7
`define SPD_SD_ALL        2'h0
`define SPD_SD_FDX_HALF   2'h1
`define SPD_SD_GIG_FDX    2'h2
`define SPD_SD_10_100     2'h3
// adv bits {10hdx,10fdx,100hdx,100fdx}; reg4 bits 8:5 order is 100fdx,100hdx,10fdx,10hdx
`define SPD_ADV_ALL       4'hf
`define SPD_ADV_NONE      4'h0
`define SPD_SETTLE_CNT    2'h3
`endif

/* File: src/spd_pkg.sv */
package spd_pkg;
    typedef enum logic [1:0] {SPD_IDLE, SPD_SETTLE, SPD_LOADED} spd_state_t;

    typedef struct packed {
        logic       downshift_en;
        logic [3:0] adv_base_t;
        logic [1:0] adv_gig;
        logic       adv_asym_pause;
        logic       adv_sym_pause;
        logic       mac_aneg_en;
        logic       link_down_power_save;
        logic [2:0] media_sel;
        logic       media_rsvd;
        logic       fiber_aneg_en;
        logic       signal_detect_input_pol;
        logic       ref_clk_fast;
        logic       clock_output_en;
        logic       led_combine_dis;
        logic [1:0] led_blink_rate;
        logic [3:0] indicator_sep;
        logic [7:0] indicator_func;
        logic       addr_reverse;
        logic [1:0] addr_hi;
    } spd_settings_t;
endpackage : spd_pkg

/* File: src/spd_sync.sv */
`timescale 1ns/10ps
`include "spd_cfg.svh"
module spd_sync (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire logic                    clk_en,
    input  wire logic [`SPD_CODE_W-1:0]  pin_code,
    output logic      [`SPD_CODE_W-1:0]  code,
    output logic                         stable
);
    logic [`SPD_CODE_W-1:0] s1;
    logic [`SPD_CODE_W-1:0] s2;
    logic [`SPD_CODE_W-1:0] s3;
    logic [`SPD_CODE_W-1:0] next_code;

    // --------------------------------------------------------
    // three-stage capture, accept when stages two and three agree
    // --------------------------------------------------------
    always_comb
    begin
        next_code = (s2 == s3) ? s3 : code;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1   <= 4'h0;
            s2   <= 4'h0;
            s3   <= 4'h0;
            code <= 4'h0;
        end
        else if (clk_en)
        begin
            s1   <= pin_code;
            s2   <= s1;
            s3   <= s2;
            code <= next_code;
        end
    end

    // code must have caught up with the agreeing stages, or a late pin edge latches a stale code
    assign stable = (s2 == s3) && (code == s3);
endmodule : spd_sync

/* File: src/spd_strap_decode.sv */
`timescale 1ns/10ps
`include "spd_cfg.svh"
module spd_strap_decode (
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst_b,
    input  wire logic                                   clk_en,
    input  wire logic [`SPD_NUM_PINS*`SPD_CODE_W-1:0]   strap_config_pin,
    output spd_pkg::spd_settings_t                      settings,
    output logic [`SPD_NUM_PORTS*`SPD_ADDR_W-1:0]       port_addr,
    output logic                                        preset_load,
    output logic                                        settings_valid
);
    logic [`SPD_NUM_PINS*`SPD_CODE_W-1:0] code_all;
    logic [`SPD_NUM_PINS-1:0]             stable_all;
    logic [`SPD_CODE_W-1:0]               cp [`SPD_NUM_PINS];
    spd_pkg::spd_state_t                  state;
    spd_pkg::spd_state_t                  next_state;
    logic [1:0]                           settle;
    logic [1:0]                           next_settle;
    spd_pkg::spd_settings_t               dec;
    spd_pkg::spd_settings_t               next_settings;
    logic [`SPD_NUM_PORTS*`SPD_ADDR_W-1:0] dec_addr;
    logic [`SPD_NUM_PORTS*`SPD_ADDR_W-1:0] next_port_addr;
    logic                                  next_load;
    logic [`SPD_NUM_IND-1:0]               ind_sep;
    logic [2*`SPD_NUM_IND-1:0]             ind_func;

    // --------------------------------------------------------
    // per-pin capture
    // --------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SPD_NUM_PINS; g = g + 1)
        begin : g_pin
            spd_sync u_sync (
                .sys_clk  (sys_clk),
                .rst_b    (rst_b),
                .clk_en   (clk_en),
                .pin_code (strap_config_pin[g*`SPD_CODE_W +: `SPD_CODE_W]),
                .code     (code_all[g*`SPD_CODE_W +: `SPD_CODE_W]),
                .stable   (stable_all[g])
            );
            assign cp[g] = code_all[g*`SPD_CODE_W +: `SPD_CODE_W];
        end
    endgenerate

    // --------------------------------------------------------
    // per-indicator fields
    // --------------------------------------------------------
    generate
        for (g = 0; g < `SPD_NUM_IND; g = g + 1)
        begin : g_ind
            assign ind_sep[g]         = cp[g][`SPD_BIT_MID];
            assign ind_func[g*2 +: 2] = cp[g][1:0];
        end
    endgenerate

    // --------------------------------------------------------
    // field decode
    // --------------------------------------------------------
    always_comb
    begin
        dec = '0;
        dec.downshift_en = cp[`SPD_PIN_SPEED][`SPD_BIT_MID];
        unique case (cp[`SPD_PIN_SPEED][1:0])
            `SPD_SD_ALL:
            begin
                dec.adv_base_t = `SPD_ADV_ALL;
                dec.adv_gig    = 2'h3;
            end
            `SPD_SD_FDX_HALF:
            begin
                dec.adv_base_t = `SPD_ADV_ALL;
                dec.adv_gig    = 2'h2;
            end
            `SPD_SD_GIG_FDX:
            begin
                dec.adv_base_t = `SPD_ADV_NONE;
                dec.adv_gig    = 2'h2;
            end
            `SPD_SD_10_100:
            begin
                dec.adv_base_t = `SPD_ADV_ALL;
                dec.adv_gig    = 2'h0;
            end
        endcase

        dec.mac_aneg_en          = cp[`SPD_PIN_MAC][`SPD_BIT_HI];
        dec.link_down_power_save = cp[`SPD_PIN_MAC][`SPD_BIT_MID];
        dec.adv_asym_pause = cp[`SPD_PIN_MAC][`SPD_BIT_ONE];
        dec.adv_sym_pause  = cp[`SPD_PIN_MAC][`SPD_BIT_ZERO];
        dec.media_sel  = {cp[`SPD_PIN_MEDIA2][`SPD_BIT_HI], cp[`SPD_PIN_MEDIA1][`SPD_BIT_HI],
                          cp[`SPD_PIN_MEDIA0][`SPD_BIT_HI]};

        unique case (dec.media_sel)
            `SPD_MEDIA_COPPER,
            `SPD_MEDIA_PASS,
            `SPD_MEDIA_100X,
            `SPD_MEDIA_AS_PASS,
            `SPD_MEDIA_AS_100:
            begin
                // pass-through leaves negotiation to the module beyond the serdes
                dec.fiber_aneg_en = 1'b0;
                dec.media_rsvd    = 1'b0;
            end
            `SPD_MEDIA_1000X,
            `SPD_MEDIA_AS_1000:
            begin
                dec.fiber_aneg_en = 1'b1;
                dec.media_rsvd    = 1'b0;
            end
            `SPD_MEDIA_RSVD:
            begin
                // reserved code is flagged, not remapped, so the consumer decides
                dec.fiber_aneg_en = 1'b0;
                dec.media_rsvd    = 1'b1;
            end
        endcase

        // signal detect, clock speed, clock output
        dec.signal_detect_input_pol = cp[`SPD_PIN_MEDIA2][`SPD_BIT_MID];
        dec.ref_clk_fast            = cp[`SPD_PIN_MEDIA2][`SPD_BIT_ONE];
        dec.clock_output_en         = cp[`SPD_PIN_MEDIA2][`SPD_BIT_ZERO];
        dec.led_combine_dis = cp[`SPD_PIN_MEDIA1][`SPD_BIT_MID];
        dec.led_blink_rate  = cp[`SPD_PIN_MEDIA1][1:0];
        dec.indicator_sep  = ind_sep;
        dec.indicator_func = ind_func;

        dec.addr_reverse = cp[`SPD_PIN_REV][`SPD_BIT_HI];
        dec.addr_hi      = {cp[`SPD_PIN_ADDR4][`SPD_BIT_HI], cp[`SPD_PIN_ADDR3][`SPD_BIT_HI]};
    end

    // --------------------------------------------------------
    // per-port address
    // --------------------------------------------------------
    generate
        for (g = 0; g < `SPD_NUM_PORTS; g = g + 1)
        begin : g_port
            localparam logic [2:0] PORT_IDX = 3'(g);
            logic [2:0]            port_low;
            assign port_low = dec.addr_reverse ? (`SPD_PORT_MAX - PORT_IDX) : PORT_IDX;
            // strapped high bits shared by every port, port index gives the low three bits
            assign dec_addr[g*`SPD_ADDR_W +: `SPD_ADDR_W] = {dec.addr_hi, port_low};
        end
    endgenerate

    // --------------------------------------------------------
    // one-shot sampling after reset release
    // --------------------------------------------------------
    always_comb
    begin
        next_state     = state;
        next_settle    = settle;
        next_settings  = settings;
        next_port_addr = port_addr;
        next_load      = 1'b0;
        unique case (state)
            spd_pkg::SPD_IDLE:
            begin
                next_state = spd_pkg::SPD_SETTLE;
            end
            spd_pkg::SPD_SETTLE:
            begin
                // wait for the capture chain to fill and agree before latching
                if (settle != `SPD_SETTLE_CNT)
                begin
                    next_settle = settle + 2'h1;
                end
                else if (&stable_all)
                begin
                    next_settings  = dec;
                    next_port_addr = dec_addr;
                    next_load      = 1'b1;
                    next_state     = spd_pkg::SPD_LOADED;
                end
            end
            spd_pkg::SPD_LOADED:
            begin
                // straps are not re-read, so later pin motion has no effect
                next_state = spd_pkg::SPD_LOADED;
            end
            default:
            begin
                next_state = spd_pkg::SPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state       <= spd_pkg::SPD_IDLE;
            settle      <= 2'h0;
            settings    <= '0;
            port_addr   <= '0;
            preset_load <= 1'b0;
        end
        else if (clk_en)
        begin
            state       <= next_state;
            settle      <= next_settle;
            settings    <= next_settings;
            port_addr   <= next_port_addr;
            preset_load <= next_load;
        end
    end

    assign settings_valid = (state == spd_pkg::SPD_LOADED);
endmodule : spd_strap_decode

/* File: test/spd_strap_board.sv */
`timescale 1ns/10ps
module spd_strap_board (
    input  wire logic [31:0] strap_code,
    output logic      [31:0] strap_config_pin
);
    // resistor straps are static levels; a ground tie gives code 0000
    // reserved top bit of pin 7 strapped low
    assign strap_config_pin = {1'b0, strap_code[30:0]};
endmodule : spd_strap_board

/* File: test/spd_strap_decode_assertions.sv */
`timescale 1ns/10ps
module spd_strap_decode_assertions (
    input wire logic                   sys_clk,
    input wire logic                   rst_b,
    input wire logic                   clk_en,
    input wire logic [31:0]            strap_config_pin,
    input wire spd_pkg::spd_settings_t settings,
    input wire logic [39:0]            port_addr,
    input wire logic                   preset_load,
    input wire logic                   settings_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_ds; preset_load |-> settings.downshift_en == strap_config_pin[30]; endproperty
    a_ds: assert property (p_ds) else $error("downshift preset wrong");
    property p_mac; preset_load |-> {settings.mac_aneg_en, settings.link_down_power_save,
        settings.adv_asym_pause, settings.adv_sym_pause} == strap_config_pin[27:24]; endproperty
    a_mac: assert property (p_mac) else $error("pin 6 presets wrong");
    property p_media; preset_load |-> settings.media_sel ==
        {strap_config_pin[23], strap_config_pin[19], strap_config_pin[15]}; endproperty
    a_media: assert property (p_media) else $error("media select wrong");
    property p_fib; settings_valid |-> settings.fiber_aneg_en ==
        (settings.media_sel == 3'h2 || settings.media_sel == 3'h6); endproperty
    a_fib: assert property (p_fib) else $error("fiber autoneg wrong");
    property p_clk; preset_load |-> {settings.signal_detect_input_pol, settings.ref_clk_fast,
        settings.clock_output_en} == strap_config_pin[22:20]; endproperty
    a_clk: assert property (p_clk) else $error("pin 5 presets wrong");
    property p_addr; preset_load |-> settings.addr_reverse == strap_config_pin[11] &&
        settings.addr_hi == {strap_config_pin[7], strap_config_pin[3]}; endproperty
    a_addr: assert property (p_addr) else $error("address straps wrong");
    property p_port; preset_load |->
        port_addr[4:0] == {strap_config_pin[7], strap_config_pin[3],
            strap_config_pin[11] ? 3'h7 : 3'h0} &&
        port_addr[39:35] == {strap_config_pin[7], strap_config_pin[3],
            strap_config_pin[11] ? 3'h0 : 3'h7}; endproperty
    a_port: assert property (p_port) else $error("port address wrong");
    property p_hold; settings_valid |=> settings_valid && $stable(settings) && $stable(port_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("loaded settings moved");
    property p_pulse; $rose(settings_valid) |-> preset_load ##1 !preset_load; endproperty
    a_pulse: assert property (p_pulse) else $error("load pulse wrong");
    property p_late; $rose(rst_b) |-> !settings_valid [*5]; endproperty
    a_late: assert property (p_late) else $error("load too early");
endmodule : spd_strap_decode_assertions

bind spd_strap_decode spd_strap_decode_assertions u_spd_strap_decode_assertions (
    .sys_clk, .rst_b, .clk_en, .strap_config_pin, .settings, .port_addr, .preset_load,
    .settings_valid);

/* File: test/test_strap_pin_config_decode.sv */
`timescale 1ns/10ps
module test_strap_pin_config_decode;
    logic                   sys_clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   clk_en = 1'b1;
    logic [31:0]            strap_code = 32'h0000_0000;
    logic [31:0]            strap_config_pin;
    spd_pkg::spd_settings_t settings;
    spd_pkg::spd_settings_t exp_set;
    logic [39:0]            port_addr;
    logic                   preset_load;
    logic                   settings_valid;
    logic [31:0]            seed = 32'h0000_16ef;
    int                     failures = 0;
    int                     n_tests = 0;
    int                     k;

    always #4 sys_clk = ~sys_clk;

    spd_strap_board u_spd_strap_board (.strap_code(strap_code),
        .strap_config_pin(strap_config_pin));
    spd_strap_decode u_spd_strap_decode (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .strap_config_pin(strap_config_pin), .settings(settings), .port_addr(port_addr),
        .preset_load(preset_load), .settings_valid(settings_valid));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic spd_pkg::spd_settings_t expect_of(input logic [31:0] p);
        spd_pkg::spd_settings_t e;
        e.downshift_en = p[30];
        // only the gigabit-only code drops the 10/100 advertisement
        e.adv_base_t = (p[29:28] == 2'h2) ? 4'h0 : 4'hf;
        e.adv_gig = (p[29:28] == 2'h0) ? 2'h3 : (p[29:28] == 2'h3) ? 2'h0 : 2'h2;
        {e.mac_aneg_en, e.link_down_power_save, e.adv_asym_pause, e.adv_sym_pause} = p[27:24];
        e.media_sel = {p[23], p[19], p[15]};
        e.media_rsvd = e.media_sel == 3'h4;
        e.fiber_aneg_en = e.media_sel == 3'h2 || e.media_sel == 3'h6;
        {e.signal_detect_input_pol, e.ref_clk_fast, e.clock_output_en} = p[22:20];
        e.led_combine_dis = p[18];
        e.led_blink_rate = p[17:16];
        for (int i = 0; i < 4; i++)
        begin
            e.indicator_sep[i] = p[4*i+2];
            e.indicator_func[2*i+:2] = p[4*i+:2];
        end
        e.addr_reverse = p[11];
        e.addr_hi = {p[7], p[3]};
        return e;
    endfunction : expect_of

    function automatic logic [4:0] addr_of(input spd_pkg::spd_settings_t e, input int n);
        return {e.addr_hi, e.addr_reverse ? 3'(7 - n) : 3'(n)};
    endfunction : addr_of

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        for (int it = 0; it < 16; it++)
        begin
            @(negedge sys_clk);
            rst_b = 1'b0;
            strap_code = rnd();
            // first passes walk every media and speed code, the rest stay random
            if (it < 8)
                {strap_code[23], strap_code[19], strap_code[15], strap_code[29:28]} = {it[2:0],
                    it[1:0]};
            repeat (12) @(negedge sys_clk);
            check("reset_out", {settings_valid, preset_load, settings}, 64'h0);
            rst_b = 1'b1;
            k = 0;
            // odd passes stall the clock enable while settling
            while (k < 60)
            begin
                @(negedge sys_clk);
                if (preset_load)
                    break;
                clk_en = it[0] ? 1'(rnd() >> 7) : 1'b1;
                k++;
            end
            clk_en = 1'b1;
            check("load_seen", k < 60, 1'b1);
            if (k >= 60)
                report_and_stop();
            exp_set = expect_of(strap_config_pin);
            check("settings", settings, exp_set);
            for (int n = 0; n < 8; n++)
                check("addr", port_addr[5*n+:5], addr_of(exp_set, n));
            // the checker holds the load pulse against the pins, so move them only after it
            @(negedge sys_clk);
            check("pulse_end", preset_load, 1'b0);
            strap_code = ~strap_code;
            repeat (8) @(negedge sys_clk);
            check("held", {settings_valid, preset_load, settings}, {2'b10, exp_set});
            check("held_addr", port_addr[4:0], addr_of(exp_set, 0));
        end
        report_and_stop();
    end
endmodule : test_strap_pin_config_decode
